// File: rtl/ppm_pkg.sv
package ppm_pkg;
  // ----------------------------------------
  // Configuration word layout
  // ----------------------------------------
  localparam logic [7:0] PPM_CAP_OFFSET  = 8'h34;
  localparam logic [7:0] PPM_CSR_OFFSET  = 8'h38;
  localparam logic [1:0] PPM_PS_LSB      = 2'h0;
  localparam logic [3:0] PPM_WEE_BIT     = 4'h8;
  localparam logic [3:0] PPM_DSEL_LSB    = 4'h9;
  localparam logic [3:0] PPM_DSCALE_LSB  = 4'hD;
  localparam logic [3:0] PPM_WES_BIT     = 4'hF;
  localparam logic [2:0] PPM_BPCC_BIT    = 3'h7;
  localparam logic [2:0] PPM_B2B3_BIT    = 3'h6;
  localparam logic [4:0] PPM_WAKE_CAP_NONE = 5'h00;
  localparam logic [7:0] PPM_DATA_VALUE  = 8'h00;
  localparam logic [7:0] PPM_BSE_VALUE   = 8'h00;
  localparam logic [1:0] PPM_DSCALE_VALUE = 2'h0;
  localparam logic [3:0] PPM_DSEL_RESET  = 4'h0;

  // Power state encodings
  typedef enum logic [1:0]
  {
    PPM_D0    = 2'h0,
    PPM_D1    = 2'h1,
    PPM_D2    = 2'h2,
    PPM_D3HOT = 2'h3
  } ppm_pstate_e;

  // Secondary bus states, one-hot
  typedef enum logic [3:0]
  {
    PPM_B0 = 4'h1,
    PPM_B1 = 4'h2,
    PPM_B2 = 4'h4,
    PPM_B3 = 4'h8
  } ppm_bus_e;
endpackage : ppm_pkg

// File: rtl/ppm_control_status.sv
module ppm_control_status
#(
  parameter logic [4:0] WAKE_CAP        = 5'h19,
  parameter bit         D1_SUPPORT      = 1'b1,
  parameter bit         D2_SUPPORT      = 1'b1,
  parameter bit         BUS_CTRL_ENABLE = 1'b0,
  parameter bit         D3HOT_STOP_CLK  = 1'b0
)
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        wake_d3cold_in,
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [3:0]  cfg_be_in,
  input  wire logic [31:0] cfg_wdata_in,
  input  wire logic        wake_cond_in,
  output logic [31:0]      cfg_rdata_out,
  output logic             cfg_ack_out,
  output logic             wake_n_out,
  output logic [1:0]       power_state_out,
  output logic             sec_clk_stop_out,
  output logic             sec_power_off_out
);
  import ppm_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [1:0]  power_state_reg;
  logic        wake_event_enable_reg;
  logic        wake_event_status_reg;
  logic [3:0]  data_select_reg;
  logic        sticky_mode_reg;
  logic        first_reg;
  logic [31:0] rdata_reg;
  logic        ack_reg;
  logic        wake_n_reg;
  logic        clk_stop_reg;
  logic        power_off_reg;
  ppm_bus_e    bus_state;

  // ----------------------------------------
  // Support check
  // ----------------------------------------
  // Power state support check, used by the write decode only
  // D0 and D3hot are mandatory, so only D1 and D2 depend on build options
  function automatic logic ppm_supported(input logic [1:0] st);
    ppm_supported = (st == PPM_D0) || (st == PPM_D3HOT) ||
                    ((st == PPM_D1) && D1_SUPPORT) ||
                    ((st == PPM_D2) && D2_SUPPORT);
  endfunction : ppm_supported

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire        csr_hit     = (cfg_addr_in == PPM_CSR_OFFSET);
  wire        wr_lo       = cfg_wr_in && csr_hit && cfg_be_in[0];
  wire        wr_hi       = cfg_wr_in && csr_hit && cfg_be_in[1];
  wire [1:0]  ps_wdata    = cfg_wdata_in[PPM_PS_LSB +: 2];
  wire        ps_load     = wr_lo && ppm_supported(ps_wdata);
  wire        wake_capable = (WAKE_CAP != PPM_WAKE_CAP_NONE);
  wire        wee_load    = wr_hi && wake_capable;
  wire        wes_clear   = wr_hi && cfg_wdata_in[PPM_WES_BIT];
  wire        wes_next    = wake_cond_in || (wake_event_status_reg && !wes_clear);
  wire        wake_assert = wes_next && wake_event_enable_reg;
  // bridge byte from build options
  // Enable and action bits mirror the hardwired bus policy, so software
  // sees exactly what the secondary bus logic does; low bits reserved
  wire        bse_en_bit  = BUS_CTRL_ENABLE;
  wire        bse_act_bit = BUS_CTRL_ENABLE && D3HOT_STOP_CLK;
  wire [7:0]  bse_byte    = {bse_en_bit, bse_act_bit, PPM_BSE_VALUE[5:0]};
  wire [15:0] csr_word    = {wake_event_status_reg, PPM_DSCALE_VALUE, data_select_reg,
                             wake_event_enable_reg, 6'h00, power_state_reg};
  wire [31:0] read_word   = csr_hit ? {PPM_DATA_VALUE, bse_byte, csr_word} : 32'h0000_0000;

  // ----------------------------------------
  // Secondary bus mapping
  // ----------------------------------------
  // Only meaningful for a bridge configuration; otherwise the outputs idle
  always_comb
  begin
    case (power_state_reg)
      PPM_D0:    bus_state = PPM_B0;
      PPM_D1:    bus_state = PPM_B1;
      PPM_D2:    bus_state = PPM_B2;
      PPM_D3HOT: bus_state = D3HOT_STOP_CLK ? PPM_B2 : PPM_B3;
      default:   bus_state = PPM_B0;
    endcase
  end

  wire bus_stop = BUS_CTRL_ENABLE && (bus_state == PPM_B2 || bus_state == PPM_B3);
  wire bus_off  = BUS_CTRL_ENABLE && (bus_state == PPM_B3);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // ----------------------------------------
  // Wake-from-D3cold strap
  // ----------------------------------------
  // Strap caught at the first edge after reset release; it only matters
  // to the next reset, so a strap that moves mid-run changes nothing now
  always_ff @(posedge clk_in)
  begin
    first_reg <= srst_in;
    if (!srst_in && first_reg)
      sticky_mode_reg <= wake_d3cold_in;
  end

  // Keep wake bits only when captured mode and live strap agree; at
  // power-up the mode is unknown, and a low strap must still clear them
  wire keep_wake = sticky_mode_reg && wake_d3cold_in;

  // ----------------------------------------
  // Wake bits
  // ----------------------------------------
  // Wake bits: sticky across reset in D3cold mode
  always_ff @(posedge clk_in)
  begin
    if (srst_in && !keep_wake)
    begin
      wake_event_enable_reg <= 1'b0;
      wake_event_status_reg <= 1'b0;
    end
    else if (!srst_in)
    begin
      if (wee_load)
        wake_event_enable_reg <= cfg_wdata_in[PPM_WEE_BIT];
      wake_event_status_reg <= wes_next;
    end
  end

  // ----------------------------------------
  // Power state and bus side
  // ----------------------------------------
  // Power state, data select and bus side
  // Bus outputs lag the state by one edge; cheaper than a combinational
  // path to the pins, and the secondary bus cannot react faster anyway
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      power_state_reg <= PPM_D0;
      data_select_reg <= PPM_DSEL_RESET;
      wake_n_reg      <= 1'b1;
      clk_stop_reg    <= 1'b0;
      power_off_reg   <= 1'b0;
    end
    else
    begin
      if (ps_load)
        power_state_reg <= ps_wdata;
      if (wr_hi)
        data_select_reg <= cfg_wdata_in[PPM_DSEL_LSB +: 4];
      wake_n_reg    <= !wake_assert;
      clk_stop_reg  <= bus_stop;
      power_off_reg <= bus_off;
    end
  end

  // ----------------------------------------
  // Access answer
  // ----------------------------------------
  // Access answer, one cycle after the strobe
  // Read data is zero outside the answer cycle so a stale word never leaks
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg   <= cfg_wr_in || cfg_rd_in;
      rdata_reg <= cfg_rd_in ? read_word : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is a flop, straight to the pin
  assign cfg_rdata_out     = rdata_reg;
  assign cfg_ack_out       = ack_reg;
  assign wake_n_out        = wake_n_reg;
  assign power_state_out   = power_state_reg;
  assign sec_clk_stop_out  = clk_stop_reg;
  assign sec_power_off_out = power_off_reg;
endmodule : ppm_control_status

// File: testbench/ppm_props.sv
module ppm_props
#(parameter bit D2_OK = 1'b1)
(
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic        cfg_wr_in,
  input wire logic        cfg_rd_in,
  input wire logic [7:0]  cfg_addr_in,
  input wire logic [3:0]  cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic        wake_cond_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic        cfg_ack_out,
  input wire logic        wake_n_out,
  input wire logic [1:0]  power_state_out,
  input wire logic        sec_clk_stop_out,
  input wire logic        sec_power_off_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Port checks
  // ----------------------------------------
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  // Status word writes; a disabled D2 must not be taken
  wire csr_wr = cfg_wr_in && cfg_addr_in == 8'h38;
  wire ps_ok  = csr_wr && cfg_be_in[0] && (D2_OK || cfg_wdata_in[1:0] != 2'h2);
  ack_follows_a: assert property ((cfg_wr_in || cfg_rd_in) |=> cfg_ack_out)
    else $error("strobe without ack");
  ps_take_a: assert property (ps_ok |=> power_state_out == $past(cfg_wdata_in[1:0]))
    else $error("state not taken");
  ps_keep_a: assert property (!ps_ok |=> $stable(power_state_out))
    else $error("state moved");
  hi_zero_a: assert property (cfg_rdata_out[31:16] == 16'h0000)
    else $error("upper bytes not zero");
  rsv_zero_a: assert property (cfg_rdata_out[14:13] == 2'h0 && cfg_rdata_out[7:2] == 6'h00)
    else $error("reserved bits set");
  idle_zero_a: assert property (!cfg_ack_out |-> cfg_rdata_out == 32'h0)
    else $error("data outside answer");
  bus_quiet_a: assert property (!sec_clk_stop_out && !sec_power_off_out)
    else $error("secondary bus touched");
  wake_clr_a: assert property (csr_wr && cfg_be_in[1] && cfg_wdata_in[15] && !wake_cond_in
    |=> wake_n_out)
    else $error("wake not dropped");
  cover property (ps_ok);
  cover property ($fell(wake_n_out));
  cover property (cfg_ack_out && cfg_rdata_out[15]);
endmodule : ppm_props

bind ppm_control_status ppm_props #(.D2_OK(D2_SUPPORT)) u_props (.*);

// File: testbench/ppm_host.sv
module ppm_host
(
  input  wire logic        clk_in,
  input  wire logic        ack_in,
  input  wire logic [31:0] rdata_in,
  output logic             wr_out,
  output logic             rd_out,
  output logic [7:0]       addr_out,
  output logic [3:0]       be_out,
  output logic [31:0]      wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int          timeouts = 0;
  logic [31:0] got;
  initial
  begin
    {wr_out, rd_out, addr_out, be_out, wdata_out} = '0;
  end
  // ----------------------------------------
  // One access: one-edge strobe, bounded wait for ack
  // ----------------------------------------
  task automatic xfer(input bit w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
    int i;
    wr_out    <= w;
    rd_out    <= !w;
    addr_out  <= a;
    be_out    <= b;
    wdata_out <= d;
    // Strobe is taken at this edge; it is a one-edge pulse by contract
    @(posedge clk_in);
    wr_out    <= 1'b0;
    rd_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
    // Answer looked at mid-cycle, where it has settled
    i = 0;
    @(negedge clk_in);
    while (ack_in !== 1'b1 && i < 4)
    begin
      @(negedge clk_in);
      i++;
    end
    // raw data byte kept unscaled here
    got = rdata_in;
    if (i == 4)
      timeouts++;
    // Hand back on a rising edge so the next request starts there
    @(posedge clk_in);
  endtask : xfer
endmodule : ppm_host

// File: testbench/ppm_control_status_tb_top.sv
module ppm_control_status_tb_top
  import ppm_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 0, srst_in = 1, wake = 0, strap = 0, wr, rd, ack, wake_n, stop, off;
  logic [7:0]  addr;
  logic [3:0]  be;
  logic [31:0] wdata, rdata;
  logic [1:0]  ps;
  logic [1:0]  st [3] = '{PPM_D0, PPM_D1, PPM_D3HOT};
  int          errors = 0, n_compared = 0;
  always #50 clk_in = ~clk_in;
  ppm_host h (.clk_in(clk_in), .ack_in(ack), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .be_out(be), .wdata_out(wdata));
  ppm_control_status #(.D2_SUPPORT(1'b0)) DUT (.clk_in(clk_in), .srst_in(srst_in),
    .wake_d3cold_in(strap), .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_addr_in(addr),
    .cfg_be_in(be), .cfg_wdata_in(wdata), .wake_cond_in(wake), .cfg_rdata_out(rdata),
    .cfg_ack_out(ack), .wake_n_out(wake_n), .power_state_out(ps),
    .sec_clk_stop_out(stop), .sec_power_off_out(off));
  // ----------------------------------------
  // Access and compare helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input bit w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    h.xfer(w, a, b, d);
    if (h.timeouts > 0)
      print_verdict();
  endtask : acc
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 4'hF, 32'h0);
    chk("rdata", e, h.got);
  endtask : rd_chk
  // Wake condition for one edge, then let wake_n settle
  task automatic pulse();
    wake <= 1'b1;
    @(posedge clk_in);
    wake <= 1'b0;
    @(posedge clk_in);
  endtask : pulse
  task automatic print_verdict();
    errors += h.timeouts;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    rd_chk(PPM_CSR_OFFSET, 32'h0);
    rd_chk(8'h3C, 32'h0);
    $display("test reset done");
    foreach (st[i])
    begin
      acc(1'b1, PPM_CSR_OFFSET, 4'h1, 32'(st[i]));
      chk("state", 32'(st[i]), 32'(ps));
      rd_chk(PPM_CSR_OFFSET, 32'(st[i]));
    end
    acc(1'b1, PPM_CSR_OFFSET, 4'h1, 32'h2);
    chk("state", 32'h3, 32'(ps));
    $display("test states done");
    acc(1'b1, PPM_CSR_OFFSET, 4'hF, 32'hFFFF_FFFF);
    rd_chk(PPM_CSR_OFFSET, 32'h0000_1F03);
    chk("bus", 32'({off, stop}), 32'h0);
    $display("test fixed fields done");
    pulse();
    chk("wake_n", 32'h0, 32'(wake_n));
    rd_chk(PPM_CSR_OFFSET, 32'h0000_9F03);
    acc(1'b1, PPM_CSR_OFFSET, 4'h2, 32'h0000_9F00);
    chk("wake_n", 32'h1, 32'(wake_n));
    acc(1'b1, PPM_CSR_OFFSET, 4'h2, 32'h0000_1E00);
    pulse();
    chk("wake_n", 32'h1, 32'(wake_n));
    rd_chk(PPM_CSR_OFFSET, 32'h0000_9E03);
    $display("test wake done");
    // Strap high: first reset still clears and arms sticky mode
    strap   <= 1'b1;
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    rd_chk(PPM_CSR_OFFSET, 32'h0);
    acc(1'b1, PPM_CSR_OFFSET, 4'h2, 32'h0000_0100);
    pulse();
    rd_chk(PPM_CSR_OFFSET, 32'h0000_8100);
    // Second reset keeps both wake bits
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    rd_chk(PPM_CSR_OFFSET, 32'h0000_8100);
    chk("state", 32'h0, 32'(ps));
    $display("test sticky done");
    print_verdict();
  end
endmodule : ppm_control_status_tb_top
